// File: rtl/host_port_pkg.sv
// Package for the three-channel host port register decode.
// Assumes one system clock for the slave side and one link clock for
// host cycles; the enclosing design supplies framed host I/O cycles.
package host_port_pkg;

  // ----------------------------------------------------------------
  // Host cycle carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        write;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } host_cycle_t;

  typedef struct packed {
    logic       claim;
    logic [7:0] rdata;
  } host_resp_t;

  // ----------------------------------------------------------------
  // Fixed channel 1 and 2 decode
  // ----------------------------------------------------------------
  localparam logic [11:0] FIXED_UPPER = 12'h006;

  // ----------------------------------------------------------------
  // Slave register indices
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_BASE_HI = 5'h00;
  localparam logic [4:0] IDX_BASE_LO = 5'h01;
  localparam logic [4:0] IDX_HOST_INPUT_BYTE_1    = 5'h02;
  localparam logic [4:0] IDX_HOST_OUTPUT_BYTE_1    = 5'h05;
  localparam logic [4:0] IDX_STAT1   = 5'h08;
  localparam logic [4:0] IDX_WIN0    = 5'h10;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int POS_OBF      = 0;
  localparam int POS_IBF      = 1;
  localparam int POS_CD       = 3;
  localparam int POS_MB_SLAVE = 4;
  localparam int POS_MB_HOST  = 6;
  localparam int POS_WIN_EN   = 0;
  localparam logic [7:0] BASE_RESET   = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;

endpackage : host_port_pkg

// File: rtl/lpc_host_register_decode.sv
// Host port register decode: three channels, window registers, mailbox.
// Assumes host I/O cycles arrive already framed on the link clock, one
// at a time, and that the slave processor accesses on the system clock.
//
// Behaviour
// - Compare address with channel-3 base when enabled
// - Channel-3 match ignores bit 2, base bit0 zero
// - Window match inverts base bit 4, ignores 3:0
// - Window enable gates all window address matching
// - Host input write stores byte, latches bit 2
// - Channel-3 writes input, reads output or status
// - Window nibble zero is mailbox, others direct
// - Mailbox slots one-way each, sharing an address
// - Mailbox writes arbitrated through status flags
// - Window registers 1-15 read/write both sides
// - Fixed input registers 1,2 at 0x60 block
// - Fixed output registers 1,2 read by host
// - Fixed status registers 1,2 at bit2 one
// - Status flags read-only, slave clears output full and mailbox flags by zero
// - Status registers reset to zero
// - Data registers have no reset value
// - Input full sets on host write, slave read clears
// - Output full sets on slave write, clears on read
// - Command/data flag at status bit 3
`timescale 1ns/10ps
`default_nettype none

module lpc_host_register_decode
  import host_port_pkg::*;
(
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_lpc_clk,
  input  wire logic        i_host_valid,
  input  wire host_cycle_t i_host_cycle,
  output logic             o_host_busy,
  output logic             o_host_done,
  output host_resp_t       o_host_resp,
  input  wire logic        i_chan3_enable,
  input  wire logic        i_slv_sel,
  input  wire logic        i_slv_wr,
  input  wire logic [4:0]  i_slv_addr,
  input  wire logic [7:0]  i_slv_wdata,
  output logic [7:0]       o_slv_rdata
);

  // ----------------------------------------------------------------
  // Link domain: capture host cycle, toggle request, await ack
  // ----------------------------------------------------------------
  logic [1:0]  lrst_sync_q;
  logic        lrst;
  logic        req_tgl_q;
  logic        busy_q;
  logic        done_q;
  logic        ack_meta_q;
  logic        ack_sync_q;
  logic        ack_seen_q;
  logic        ack_edge;
  host_cycle_t cyc_q;
  host_resp_t  resp_q;
  logic        ack_tgl_q;
  host_resp_t  sys_resp_q;

  // Reset reaches the link side through its own synchroniser
  always_ff @(posedge i_lpc_clk) begin
    lrst_sync_q <= {lrst_sync_q[0], i_reset};
  end
  assign lrst     = lrst_sync_q[1];
  assign ack_edge = ack_sync_q ^ ack_seen_q;

  // Toggle handshake: one cycle in flight, so cyc_q stands still
  // while the system side reads it and needs no synchroniser there
  always_ff @(posedge i_lpc_clk) begin
    if (lrst) begin
      req_tgl_q  <= 1'b0;
      busy_q     <= 1'b0;
      done_q     <= 1'b0;
      ack_meta_q <= 1'b0;
      ack_sync_q <= 1'b0;
      ack_seen_q <= 1'b0;
      cyc_q      <= '0;
      resp_q     <= '0;
    end else begin
      ack_meta_q <= ack_tgl_q;
      ack_sync_q <= ack_meta_q;
      ack_seen_q <= ack_sync_q;
      done_q     <= ack_edge;
      if (ack_edge) begin
        busy_q <= 1'b0;
        // Safe: sys side holds its answer until the next request
        resp_q <= sys_resp_q;
      end
      if (i_host_valid && !busy_q) begin
        cyc_q     <= i_host_cycle;
        req_tgl_q <= ~req_tgl_q;
        busy_q    <= 1'b1;
      end
    end
  end

  assign o_host_busy = busy_q;
  assign o_host_done = done_q;
  assign o_host_resp = resp_q;

  // ----------------------------------------------------------------
  // System domain: request synchroniser
  // ----------------------------------------------------------------
  logic req_meta_q;
  logic req_sync_q;
  logic req_seen_q;
  logic h_go;

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
      req_seen_q <= 1'b0;
    end else begin
      req_meta_q <= req_tgl_q;
      req_sync_q <= req_meta_q;
      req_seen_q <= req_sync_q;
    end
  end
  // One system cycle of work for each toggle seen
  assign h_go = req_sync_q ^ req_seen_q;

  // ----------------------------------------------------------------
  // Channel-3 base address
  // ----------------------------------------------------------------
  logic [7:0]  base_hi_q;
  logic [7:0]  base_lo_q;
  logic [15:0] base;
  logic        s_wr;
  logic        s_rd;
  logic        s_base_hi_wr;
  logic        s_base_lo_wr;

  assign s_wr = i_slv_sel & i_slv_wr;
  assign s_rd = i_slv_sel & ~i_slv_wr;
  assign base = {base_hi_q, base_lo_q};
  assign s_base_hi_wr = s_wr & (i_slv_addr == IDX_BASE_HI);
  assign s_base_lo_wr = s_wr & (i_slv_addr == IDX_BASE_LO);

  // Reserved bit 2 is stored like any other bit
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      base_hi_q <= BASE_RESET;
      base_lo_q <= BASE_RESET;
    end else begin
      if (s_base_hi_wr) base_hi_q <= i_slv_wdata;
      if (s_base_lo_wr) base_lo_q <= i_slv_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Host address decode
  // ----------------------------------------------------------------
  logic [15:0] a;
  logic        h_write;
  logic [3:0]  nib;
  logic        fix_hit;
  logic        c3_hit;
  logic        win_hit;
  logic        chan_hit;
  logic [1:0]  h_ch;
  logic        h_idr_wr;
  logic        h_odr_rd;
  logic        h_win_wr;
  logic        h_mb_wr;
  logic        s_mb_wr;

  assign a       = cyc_q.addr;
  assign h_write = cyc_q.write;
  assign nib     = a[3:0];
  assign fix_hit = (a[15:4] == FIXED_UPPER) & ~a[3] & ~a[0];
  assign c3_hit  = i_chan3_enable & (a[15:3] == base[15:3])
                 & (a[1] == base[1]) & ~a[0];
  // Window and channel 3 share the base but differ in bit 4
  assign win_hit = i_chan3_enable & base_lo_q[POS_WIN_EN]
                 & (a[15:5] == base[15:5]) & (a[4] == ~base[4]);
  assign chan_hit = c3_hit | fix_hit;
  // Channel 3 wins over the fixed block if software overlaps them
  assign h_ch     = c3_hit ? 2'd2 : {1'b0, a[1]};
  // Writes ignore bit 2 for selection; reads use it for status
  assign h_idr_wr = h_go & chan_hit & ~win_hit & h_write;
  assign h_odr_rd = h_go & chan_hit & ~win_hit & ~h_write & ~a[2];
  assign h_win_wr = h_go & win_hit & h_write;

  // ----------------------------------------------------------------
  // Mailbox slots and arbitration flags
  // ----------------------------------------------------------------
  logic [7:0] mb_from_host_q;
  logic [7:0] mb_to_host_q;
  logic       mb_host_q;
  logic       mb_slave_q;
  logic       s_stat3_wr;

  // A write is valid only while the other side's flag is clear;
  // a same-cycle collision goes to the host
  assign h_mb_wr = h_win_wr & (nib == 4'h0) & ~mb_slave_q;
  assign s_mb_wr = s_wr & (i_slv_addr == IDX_WIN0)
                 & ~mb_host_q & ~h_mb_wr;
  assign s_stat3_wr = s_wr & (i_slv_addr == IDX_STAT1 + 5'd2);

  // Mailbox bytes need no reset; their flags tell when they are valid
  always_ff @(posedge i_sys_clk) begin
    if (h_mb_wr) mb_from_host_q <= cyc_q.wdata;
    if (s_mb_wr) mb_to_host_q <= i_slv_wdata;
  end

  // Set wins over a clear in the same cycle
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      mb_host_q  <= 1'b0;
      mb_slave_q <= 1'b0;
    end else begin
      mb_host_q  <= h_mb_wr | (mb_host_q
                  & ~(s_stat3_wr & ~i_slv_wdata[POS_MB_HOST]));
      mb_slave_q <= s_mb_wr | (mb_slave_q
                  & ~(s_stat3_wr & ~i_slv_wdata[POS_MB_SLAVE]));
    end
  end

  // ----------------------------------------------------------------
  // Window registers 1 to 15
  // ----------------------------------------------------------------
  logic [7:0] win_q [1:15];
  logic       h_win_direct;
  logic       s_win_direct;

  // Index 0 is the mailbox pair, never a plain window byte
  assign h_win_direct = h_win_wr & (nib != 4'h0);
  assign s_win_direct = s_wr & i_slv_addr[4] & (i_slv_addr[3:0] != 4'h0);

  // No reset: contents are undefined until first write; host wins
  always_ff @(posedge i_sys_clk) begin
    if (h_win_direct) begin
      win_q[nib] <= cyc_q.wdata;
    end else if (s_win_direct) begin
      win_q[i_slv_addr[3:0]] <= i_slv_wdata;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel data and status
  // ----------------------------------------------------------------
  logic [7:0] idr_q  [0:2];
  logic [7:0] odr_q  [0:2];
  logic [7:0] status [0:2];
  logic [2:0] cd_q;
  logic [2:0] ibf_q;
  logic [2:0] obf_q;
  logic [4:0] user_q [0:2];

  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic hw;
    logic hr;
    logic sw_odr;
    logic sr_idr;
    logic sw_st;

    assign hw     = h_idr_wr & (h_ch == 2'(c));
    assign hr     = h_odr_rd & (h_ch == 2'(c));
    assign sw_odr = s_wr & (i_slv_addr == IDX_HOST_OUTPUT_BYTE_1 + 5'(c));
    assign sr_idr = s_rd & (i_slv_addr == IDX_HOST_INPUT_BYTE_1 + 5'(c));
    assign sw_st  = s_wr & (i_slv_addr == IDX_STAT1 + 5'(c));

    always_ff @(posedge i_sys_clk) begin
      if (hw) idr_q[c] <= cyc_q.wdata;
      if (sw_odr) odr_q[c] <= i_slv_wdata;
    end

    always_ff @(posedge i_sys_clk) begin
      if (i_reset) begin
        cd_q[c]   <= STATUS_RESET[POS_CD];
        ibf_q[c]  <= STATUS_RESET[POS_IBF];
        obf_q[c]  <= STATUS_RESET[POS_OBF];
        user_q[c] <= '0;
      end else begin
        if (hw) cd_q[c] <= a[2];
        ibf_q[c] <= hw | (ibf_q[c] & ~sr_idr);
        obf_q[c] <= sw_odr | (obf_q[c] & ~hr
                  & ~(sw_st & ~i_slv_wdata[POS_OBF]));
        if (sw_st) user_q[c] <= {i_slv_wdata[7:4], i_slv_wdata[2]};
      end
    end
  end

  // Channels 1 and 2 keep user bits 7:4 and 2 around their flags
  function automatic logic [7:0] pack_status(input logic [4:0] user,
                                             input logic       cd,
                                             input logic       input_full_flag,
                                             input logic       output_full_flag);
    pack_status = {user[4:1], cd, user[0], input_full_flag, output_full_flag};
  endfunction : pack_status

  // Channel 3 upper nibble is flags only; bits 7 and 5 read zero
  assign status[0] = pack_status(user_q[0], cd_q[0],
                                 ibf_q[0], obf_q[0]);
  assign status[1] = pack_status(user_q[1], cd_q[1],
                                 ibf_q[1], obf_q[1]);
  assign status[2] = {1'b0, mb_host_q, 1'b0, mb_slave_q, cd_q[2],
                      user_q[2][0], ibf_q[2], obf_q[2]};

  // ----------------------------------------------------------------
  // Host answer
  // ----------------------------------------------------------------
  logic [7:0] h_rdata;
  logic [7:0] win_rd;

  assign win_rd  = (nib == 4'h0) ? mb_to_host_q : win_q[nib];
  assign h_rdata = h_write ? 8'h00
                 : win_hit ? win_rd
                 : chan_hit ? (a[2] ? status[h_ch] : odr_q[h_ch])
                 : 8'h00;

  // The answer stands until the next request; the link side needs that
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      ack_tgl_q  <= 1'b0;
      sys_resp_q <= '0;
    end else if (h_go) begin
      ack_tgl_q        <= ~ack_tgl_q;
      sys_resp_q.claim <= win_hit | chan_hit;
      sys_resp_q.rdata <= h_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Slave read port
  // ----------------------------------------------------------------
  logic [7:0] s_rdata;

  // Reads here change nothing; input full clears from the strobe
  always_comb begin
    s_rdata = 8'h00;
    if (i_slv_addr[4]) begin
      s_rdata = (i_slv_addr[3:0] == 4'h0) ? mb_from_host_q
              : win_rd_slave(i_slv_addr[3:0]);
    end else begin
      unique case (i_slv_addr)
        IDX_BASE_HI:         s_rdata = base_hi_q;
        IDX_BASE_LO:         s_rdata = base_lo_q;
        IDX_HOST_INPUT_BYTE_1:            s_rdata = idr_q[0];
        IDX_HOST_INPUT_BYTE_1 + 5'd1:     s_rdata = idr_q[1];
        IDX_HOST_INPUT_BYTE_1 + 5'd2:     s_rdata = idr_q[2];
        IDX_HOST_OUTPUT_BYTE_1:            s_rdata = odr_q[0];
        IDX_HOST_OUTPUT_BYTE_1 + 5'd1:     s_rdata = odr_q[1];
        IDX_HOST_OUTPUT_BYTE_1 + 5'd2:     s_rdata = odr_q[2];
        IDX_STAT1:           s_rdata = status[0];
        IDX_STAT1 + 5'd1:    s_rdata = status[1];
        IDX_STAT1 + 5'd2:    s_rdata = status[2];
        default:             s_rdata = 8'h00;
      endcase
    end
  end

  function automatic logic [7:0] win_rd_slave(input logic [3:0] idx);
    win_rd_slave = win_q[idx];
  endfunction : win_rd_slave

  // Registered so the slave sees a full cycle of settled data
  always_ff @(posedge i_sys_clk) begin
    if (i_reset) begin
      o_slv_rdata <= 8'h00;
    end else begin
      o_slv_rdata <= s_rdata;
    end
  end

endmodule : lpc_host_register_decode

`default_nettype wire

// File: bench/host_port_checker_asserts.sv
// Checker for the host port decode, bound to the top module's ports.
// Assumes base and channel-3 enable hold still during a host cycle.
`timescale 1ns/10ps
`default_nettype none

module host_port_checker
  import host_port_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_reset,
  input wire logic        i_lpc_clk,
  input wire logic        i_host_valid,
  input wire host_cycle_t i_host_cycle,
  input wire logic        o_host_busy,
  input wire logic        o_host_done,
  input wire host_resp_t  o_host_resp,
  input wire logic        i_chan3_enable,
  input wire logic        i_slv_sel,
  input wire logic        i_slv_wr,
  input wire logic [4:0]  i_slv_addr,
  input wire logic [7:0]  i_slv_wdata,
  input wire logic [7:0]  o_slv_rdata
);
  // --------------------------------------------------------------
  // Decode mirror and checks
  // --------------------------------------------------------------
  logic [15:0] base_q;
  logic [16:0] cyc_q;
  wire  [15:0] ca    = cyc_q[15:0];
  wire         slv_w = i_slv_sel && i_slv_wr;
  wire         slv_r = i_slv_sel && !i_slv_wr;
  wire         hit   = (ca[15:4] == FIXED_UPPER && !ca[3] && !ca[0]) ||
    (cyc_q[16] && ((ca ^ base_q) & 16'hfffa) == 16'h0000 && !ca[0]) ||
    (cyc_q[16] && base_q[POS_WIN_EN] &&
     ca[15:4] == (base_q[15:4] ^ 12'h001));

  always_ff @(posedge i_sys_clk) begin
    if (i_reset) base_q <= {BASE_RESET, BASE_RESET};
    else if (slv_w && i_slv_addr == IDX_BASE_HI) base_q[15:8] <= i_slv_wdata;
    else if (slv_w && i_slv_addr == IDX_BASE_LO) base_q[7:0] <= i_slv_wdata;
  end

  // Capture only at acceptance, so a late enable change is not seen
  always_ff @(posedge i_lpc_clk) begin
    if (i_host_valid && !o_host_busy)
      cyc_q <= {i_chan3_enable, i_host_cycle.addr};
  end

  sequence s_wr(logic [4:0] idx); slv_w && i_slv_addr == idx; endsequence
  sequence s_rd(logic [4:0] idx); slv_r && i_slv_addr == idx; endsequence

  AST_ANSWER_BOUND: assert property (@(posedge i_lpc_clk) disable iff (i_reset)
    i_host_valid && !o_host_busy |=> o_host_busy [*4] ##[1:24] (o_host_done && !o_host_busy))
    else $error("host answer late");
  AST_DONE_PULSE: assert property (@(posedge i_lpc_clk) disable iff (i_reset)
    o_host_done |=> !o_host_done) else $error("done too long");
  AST_CLAIM: assert property (@(posedge i_lpc_clk) disable iff (i_reset)
    o_host_done |-> o_host_resp.claim == hit) else $error("claim wrong");
  AST_UNCLAIMED_ZERO: assert property (@(posedge i_lpc_clk) disable iff (i_reset)
    o_host_done && !o_host_resp.claim |-> o_host_resp.rdata == 8'h00) else $error("stray data");
  AST_STATUS_RESET: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    $fell(i_reset) && slv_r && i_slv_addr == IDX_STAT1 |=> o_slv_rdata == STATUS_RESET)
    else $error("status not reset");
  AST_BASE_READBACK: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_wr(IDX_BASE_LO) ##2 s_rd(IDX_BASE_LO) |=> o_slv_rdata == $past(i_slv_wdata, 3))
    else $error("base low lost");
  AST_OBF_SET: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_wr(IDX_HOST_OUTPUT_BYTE_1) ##2 s_rd(IDX_STAT1) |=> o_slv_rdata[POS_OBF]) else $error("obf not set");
  AST_OBF_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    (slv_w && i_slv_addr == IDX_STAT1 && !i_slv_wdata[POS_OBF]) ##2 s_rd(IDX_STAT1)
    |=> !o_slv_rdata[POS_OBF]) else $error("obf not cleared");
  AST_IBF_CLEAR: assert property (@(posedge i_sys_clk) disable iff (i_reset)
    s_rd(IDX_HOST_INPUT_BYTE_1) ##2 s_rd(IDX_STAT1) |=> !o_slv_rdata[POS_IBF]) else $error("ibf stuck");
endmodule : host_port_checker

bind lpc_host_register_decode host_port_checker host_port_checker_inst (
  .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_lpc_clk(i_lpc_clk),
  .i_host_valid(i_host_valid), .i_host_cycle(i_host_cycle),
  .o_host_busy(o_host_busy), .o_host_done(o_host_done),
  .o_host_resp(o_host_resp), .i_chan3_enable(i_chan3_enable),
  .i_slv_sel(i_slv_sel), .i_slv_wr(i_slv_wr), .i_slv_addr(i_slv_addr),
  .i_slv_wdata(i_slv_wdata), .o_slv_rdata(o_slv_rdata));

`default_nettype wire

// File: bench/host_cycle_model.sv
// Host chipset model: issues one I/O cycle at a time on the link.
// Assumes a free-running link clock and the busy/done handshake.
`timescale 1ns/10ps
`default_nettype none

module host_cycle_model
  import host_port_pkg::*;
(
  input  wire logic       i_lpc_clk,
  input  wire logic       i_busy,
  input  wire logic       i_done,
  input  wire host_resp_t i_resp,
  output host_cycle_t     o_cycle,
  output logic            o_valid
);
  // --------------------------------------------------------------
  // Cycle driver
  // --------------------------------------------------------------
  initial begin
    o_valid = 1'b0;
    o_cycle = '0;
  end

  task automatic io(input logic w, input logic [15:0] a,
                    input logic [7:0] d, output host_resp_t r);
    int n;
    n = 0;
    @(posedge i_lpc_clk);
    o_valid <= 1'b1;
    o_cycle <= {w, a, d};
    do @(posedge i_lpc_clk); while (i_busy);
    o_valid <= 1'b0;
    // Released bus shows no stale cycle
    o_cycle <= ~o_cycle;
    do begin
      @(posedge i_lpc_clk);
      n++;
    end while (!i_done && n < 40);
    // A lost answer comes back unknown, so the bench counts it
    if (i_done) r = i_resp;
    else r = 'x;
  endtask : io
endmodule : host_cycle_model

`default_nettype wire

// File: bench/testbench.sv
// Testbench for the host port decode: slave tasks and a host model.
// Assumes the checker file binds itself to the design.
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import host_port_pkg::*;
  // --------------------------------------------------------------
  // Bench
  // --------------------------------------------------------------
  logic        clk = 1'b0;
  logic        lclk = 1'b0;
  logic        reset = 1'b1;
  logic        en3 = 1'b0;
  logic        sel = 1'b0;
  logic        wr = 1'b0;
  logic [4:0]  sa = 5'h00;
  logic [7:0]  sd = 8'h00;
  logic [7:0]  rdata;
  logic        busy;
  logic        done;
  logic        hv;
  host_cycle_t cyc;
  host_resp_t  resp;
  host_resp_t  r;
  int          n_errors = 0;
  int          total_checks = 0;

  initial forever #25 clk = ~clk;
  initial begin
    #7;
    forever #16 lclk = ~lclk;
  end

  lpc_host_register_decode lpc_host_register_decode_inst (
    .i_sys_clk(clk), .i_reset(reset), .i_lpc_clk(lclk), .i_host_valid(hv),
    .i_host_cycle(cyc), .o_host_busy(busy), .o_host_done(done),
    .o_host_resp(resp), .i_chan3_enable(en3), .i_slv_sel(sel),
    .i_slv_wr(wr), .i_slv_addr(sa), .i_slv_wdata(sd), .o_slv_rdata(rdata));
  host_cycle_model host_cycle_model_inst (.i_lpc_clk(lclk), .i_busy(busy),
    .i_done(done), .i_resp(resp), .o_cycle(cyc), .o_valid(hv));

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic sw(input logic [4:0] a, input logic [7:0] d);
    sel <= 1'b1;
    wr <= 1'b1;
    sa <= a;
    sd <= d;
    @(posedge clk);
    sel <= 1'b0;
    // Deselected bus shows no stale request
    sa <= ~a;
    sd <= ~d;
    @(posedge clk);
  endtask : sw

  task automatic sr(input logic [4:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    sel <= 1'b1;
    wr <= 1'b0;
    sa <= a;
    @(posedge clk);
    sel <= 1'b0;
    sa <= ~a;
    @(posedge clk);
    chk({1'b0, rdata & m}, {1'b0, e});
  endtask : sr

  // Writes answer no data, so only the claim is compared for them
  task automatic hc(input logic w, input logic [15:0] a, input logic [7:0] d, input logic [8:0] e);
    host_cycle_model_inst.io(w, a, d, r);
    chk({r.claim, w ? 8'h00 : r.rdata}, e);
    @(posedge clk);
  endtask : hc

  task t_reset;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    sr(IDX_STAT1, STATUS_RESET);
    sr(5'h0a, STATUS_RESET);
    sr(IDX_BASE_LO, BASE_RESET);
    $display("test reset done");
  endtask : t_reset

  task t_fixed;
    hc(1'b1, 16'h0064, 8'ha5, 9'h100);
    sr(IDX_STAT1, 8'h0a);
    sr(IDX_HOST_INPUT_BYTE_1, 8'ha5);
    sr(IDX_STAT1, 8'h08);
    hc(1'b1, 16'h0062, 8'h5a, 9'h100);
    sr(5'h09, 8'h02);
    sr(5'h03, 8'h5a);
    sw(IDX_HOST_OUTPUT_BYTE_1, 8'h3c);
    sr(IDX_STAT1, 8'h09);
    hc(1'b0, 16'h0064, 8'h00, 9'h109);
    hc(1'b0, 16'h0060, 8'h00, 9'h13c);
    sr(IDX_STAT1, 8'h08);
    sw(IDX_STAT1, 8'hff);
    sr(IDX_STAT1, 8'hfc);
    sw(IDX_HOST_OUTPUT_BYTE_1, 8'h11);
    sw(IDX_STAT1, 8'h00);
    sr(IDX_STAT1, 8'h08);
    hc(1'b0, 16'h0061, 8'h00, 9'h000);
    $display("test fixed done");
  endtask : t_fixed

  task t_chan3;
    sw(IDX_BASE_HI, 8'h0c);
    sw(IDX_BASE_LO, 8'ha8);
    sr(IDX_BASE_LO, 8'ha8);
    en3 <= 1'b1;
    hc(1'b1, 16'h0ca8, 8'h77, 9'h100);
    sr(5'h0a, 8'h02);
    hc(1'b1, 16'h0cac, 8'h78, 9'h100);
    sr(5'h0a, 8'h0a);
    sr(5'h04, 8'h78);
    sw(5'h07, 8'hc5);
    hc(1'b0, 16'h0cac, 8'h00, 9'h109);
    hc(1'b0, 16'h0ca8, 8'h00, 9'h1c5);
    en3 <= 1'b0;
    hc(1'b0, 16'h0ca8, 8'h00, 9'h000);
    sr(5'h0a, 8'h08);
    $display("test chan3 done");
  endtask : t_chan3

  task t_window;
    sw(IDX_BASE_LO, 8'ha9);
    en3 <= 1'b1;
    hc(1'b1, 16'h0cb5, 8'h66, 9'h100);
    sr(5'h15, 8'h66);
    sw(5'h1f, 8'h12);
    hc(1'b0, 16'h0cbf, 8'h00, 9'h112);
    hc(1'b1, 16'h0cb0, 8'h5a, 9'h100);
    sr(5'h0a, 8'h40, 8'h50);
    sr(IDX_WIN0, 8'h5a);
    sw(IDX_WIN0, 8'hc3);
    sr(5'h0a, 8'h40, 8'h50);
    sw(5'h0a, 8'h00);
    sw(IDX_WIN0, 8'hc3);
    sr(5'h0a, 8'h10, 8'h50);
    hc(1'b0, 16'h0cb0, 8'h00, 9'h1c3);
    // Only the window enable changes while channel 3 is on
    sw(IDX_BASE_LO, 8'ha8);
    hc(1'b0, 16'h0cbf, 8'h00, 9'h000);
    en3 <= 1'b0;
    $display("test window done");
  endtask : t_window

  task automatic final_report;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report

  initial begin
    t_reset;
    t_fixed;
    t_chan3;
    t_window;
    final_report;
  end

  // Whole run needs about ten microseconds
  initial begin
    #300000;
    n_errors++;
    $display("Error at %0t: watchdog", $time);
    final_report;
  end
endmodule : testbench

`default_nettype wire
